// *** rtl/aiw_regs.svh ***
`ifndef AIW_REGS_SVH
`define AIW_REGS_SVH

// register offsets (byte addresses on the register port)
`define AIW_OFS_SYS_STATE 8'h14
`define AIW_OFS_IRQ_SRC 8'h15
`define AIW_OFS_WAKE_CFG 8'h3A
`define AIW_OFS_IRQ_EN 8'h3B
`define AIW_OFS_IRQ_ROUTE 8'h3C

// reset values
`define AIW_RST_WAKE_CFG 8'h00
`define AIW_RST_IRQ_EN 8'h00
`define AIW_RST_IRQ_ROUTE 8'h00

// wake_select_and_pin_config fields
`define AIW_BIT_GATE 7
`define AIW_BIT_WAKE_HI 6
`define AIW_BIT_WAKE_LO 2
`define AIW_BIT_LEVEL 1
`define AIW_BIT_DRIVE 0

// source bit positions, shared by enable, routing and source registers
`define AIW_SRC_SLEEP_WAKE 7
`define AIW_SRC_BUFFER 6
`define AIW_SRC_JOLT 5
`define AIW_SRC_ORIENT 4
`define AIW_SRC_PULSE 3
`define AIW_SRC_MOTION_ONE 2
`define AIW_SRC_MOTION_TWO 1
`define AIW_SRC_READY 0

// system state register fields
`define AIW_BIT_GATE_ERR 6
`define AIW_BIT_MODE_LO 0

`endif

// *** rtl/aiw_pkg.sv ***
package aiw_pkg;
  typedef logic [7:0] aiw_byte_t;
  typedef enum logic [1:0] {
    AIW_MODE_STANDBY,
    AIW_MODE_WAKE,
    AIW_MODE_SLEEP
  } aiw_sys_mode_t;
  typedef enum logic [1:0] {
    AIW_BUF_OPEN,
    AIW_BUF_BLOCKED,
    AIW_BUF_FAULT
  } aiw_gate_state_t;
endpackage

// *** rtl/aiw_pin_drive.sv ***
`timescale 1ns/10ps
// drives one interrupt pad from a raw "asserted" level, registered
module aiw_pin_drive (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic asserted,
  input wire logic active_high,
  input wire logic open_drain,
  output logic pin_o,
  output logic pin_oe_n
);
  // ---------------------------------------------------------------
  // pad level
  // ---------------------------------------------------------------
  // reset state: active low level, pad idle high, push-pull driving
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= 1'b1;
      pin_oe_n <= 1'b0;
    end else begin
      pin_o <= asserted ~^ active_high;
      // open drain drives only while asserted, so shared lines can wire-or
      pin_oe_n <= open_drain && !asserted;
    end
  end
endmodule // aiw_pin_drive

// *** rtl/aiw_irq_wake_ctrl.sv ***
`timescale 1ns/10ps
`include "aiw_regs.svh"
// Function
// - wake-select bit 0 keeps that function from waking; 1 lets it wake
// - polarity bit 0 shows events low, 1 high; resets to 0
// - drive-type 0 push-pull, 1 open drain; resets to 0
// - gate bit 0: flush sample buffer on every wake/sleep transition
// - gate bit 1: transition blocks buffer input until host empties it
// - gate set and buffer not emptied by next sample raises gate error
// - emptying the buffer clears gate error and resumes acceptance
// - enable register gates each source flag; all reset disabled
// - routing bit 0 selects second pin, 1 first; resets 0
// - enabled sources drive their selected pin; many may share one
// - auto-sleep active and enabled: interrupt on each sleep/wake change
// - buffer, sleep/wake and ready sources never wake the device
// - control register: gate, five wake bits, polarity, drive type
module aiw_irq_wake_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire aiw_pkg::aiw_byte_t reg_addr,
  input wire aiw_pkg::aiw_byte_t reg_wdata,
  output aiw_pkg::aiw_byte_t reg_rdata,
  // event flags from the detection functions, bit order as source register
  input wire aiw_pkg::aiw_byte_t event_flags,
  input wire logic sleep_wake_ack,
  // system mode controls
  input wire logic auto_sleep_en,
  input wire logic active_mode,
  input wire logic sleep_request,
  // sample buffer status
  input wire logic sample_arrive,
  input wire logic buffer_empty,
  // outputs
  output logic buffer_flush,
  output logic buffer_input_block,
  output logic in_sleep,
  output logic irq_pin_first_o,
  output logic irq_pin_first_oe_n,
  output logic irq_pin_second_o,
  output logic irq_pin_second_oe_n
);
  import aiw_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  aiw_byte_t wake_select_and_pin_config_r;
  aiw_byte_t interrupt_source_enable_r;
  aiw_byte_t interrupt_pin_routing_r;
  aiw_sys_mode_t mode_r;
  aiw_sys_mode_t mode_nxt;
  aiw_gate_state_t gate_r;
  logic sleep_wake_flag_r;
  logic transition;
  logic wake_hit;
  aiw_byte_t src_flags;
  aiw_byte_t live;
  logic first_any;
  logic second_any;

  function automatic logic reg_hit(input aiw_byte_t a, input aiw_byte_t ofs);
    return a == ofs;
  endfunction

  // routing bit 1 steers a source to the first pin, 0 to the second
  function automatic logic pin_hit(input aiw_byte_t act, input aiw_byte_t rt,
      input logic first);
    return |(act & (first ? rt : ~rt));
  endfunction

  // ---------------------------------------------------------------
  // configuration registers, one process per register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_select_and_pin_config_r <= `AIW_RST_WAKE_CFG;
    end else if (reg_wr && reg_hit(reg_addr, `AIW_OFS_WAKE_CFG)) begin
      wake_select_and_pin_config_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_source_enable_r <= `AIW_RST_IRQ_EN;
    end else if (reg_wr && reg_hit(reg_addr, `AIW_OFS_IRQ_EN)) begin
      interrupt_source_enable_r <= reg_wdata;
    end
  end

  // the source and state registers are read-only; writes to them are lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_routing_r <= `AIW_RST_IRQ_ROUTE;
    end else if (reg_wr && reg_hit(reg_addr, `AIW_OFS_IRQ_ROUTE)) begin
      interrupt_pin_routing_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // wake / sleep state
  // ---------------------------------------------------------------
  // only the five detection functions can wake; buffer, sleep/wake
  // and ready bits are left out of the mask on purpose
  assign wake_hit =
      |(event_flags[`AIW_SRC_JOLT:`AIW_SRC_MOTION_TWO]
      & wake_select_and_pin_config_r[`AIW_BIT_WAKE_HI:`AIW_BIT_WAKE_LO]);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      AIW_MODE_STANDBY: begin
        if (active_mode) begin
          mode_nxt = AIW_MODE_WAKE;
        end
      end
      AIW_MODE_WAKE: begin
        if (!active_mode) begin
          mode_nxt = AIW_MODE_STANDBY;
        end else if (auto_sleep_en && sleep_request && !wake_hit) begin
          mode_nxt = AIW_MODE_SLEEP;
        end
      end
      AIW_MODE_SLEEP: begin
        if (!active_mode) begin
          mode_nxt = AIW_MODE_STANDBY;
        end else if (wake_hit || !auto_sleep_en) begin
          mode_nxt = AIW_MODE_WAKE;
        end
      end
      default: mode_nxt = AIW_MODE_STANDBY;
    endcase
  end

  assign transition = (mode_r == AIW_MODE_WAKE && mode_nxt == AIW_MODE_SLEEP)
      || (mode_r == AIW_MODE_SLEEP && mode_nxt == AIW_MODE_WAKE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= AIW_MODE_STANDBY;
      in_sleep <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      in_sleep <= mode_nxt == AIW_MODE_SLEEP;
    end
  end

  // ---------------------------------------------------------------
  // sleep/wake event flag
  // ---------------------------------------------------------------
  // set wins over the host acknowledge in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_wake_flag_r <= 1'b0;
    end else if (transition && auto_sleep_en) begin
      sleep_wake_flag_r <= 1'b1;
    end else if (sleep_wake_ack) begin
      sleep_wake_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // buffer gate
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_flush <= 1'b0;
    end else begin
      buffer_flush <= transition
          && !wake_select_and_pin_config_r[`AIW_BIT_GATE];
    end
  end

  // block is set beside the state so the output comes from a flip-flop;
  // it stays high in both blocked states and arriving samples are dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= AIW_BUF_OPEN;
      buffer_input_block <= 1'b0;
    end else begin
      case (gate_r)
        AIW_BUF_OPEN: begin
          if (transition && wake_select_and_pin_config_r[`AIW_BIT_GATE]
              && !buffer_empty) begin
            gate_r <= AIW_BUF_BLOCKED;
            buffer_input_block <= 1'b1;
          end
        end
        AIW_BUF_BLOCKED: begin
          if (buffer_empty) begin
            gate_r <= AIW_BUF_OPEN;
            buffer_input_block <= 1'b0;
          end else if (sample_arrive) begin
            gate_r <= AIW_BUF_FAULT;
          end
        end
        AIW_BUF_FAULT: begin
          if (buffer_empty) begin
            gate_r <= AIW_BUF_OPEN;
            buffer_input_block <= 1'b0;
          end
        end
        default: begin
          gate_r <= AIW_BUF_OPEN;
          buffer_input_block <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt routing
  // ---------------------------------------------------------------
  always_comb begin
    src_flags = event_flags;
    src_flags[`AIW_SRC_SLEEP_WAKE] = sleep_wake_flag_r;
  end

  assign live = src_flags & interrupt_source_enable_r;
  assign first_any = pin_hit(live, interrupt_pin_routing_r,
      1'b1);
  assign second_any = pin_hit(live, interrupt_pin_routing_r,
      1'b0);

  aiw_pin_drive u_pin_first (
    .mclk(mclk),
    .rst_n(rst_n),
    .asserted(first_any),
    .active_high(wake_select_and_pin_config_r[`AIW_BIT_LEVEL]),
    .open_drain(wake_select_and_pin_config_r[`AIW_BIT_DRIVE]),
    .pin_o(irq_pin_first_o),
    .pin_oe_n(irq_pin_first_oe_n)
  );

  aiw_pin_drive u_pin_second (
    .mclk(mclk),
    .rst_n(rst_n),
    .asserted(second_any),
    .active_high(wake_select_and_pin_config_r[`AIW_BIT_LEVEL]),
    .open_drain(wake_select_and_pin_config_r[`AIW_BIT_DRIVE]),
    .pin_o(irq_pin_second_o),
    .pin_oe_n(irq_pin_second_oe_n)
  );

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // registered read data; unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AIW_OFS_SYS_STATE: begin
          reg_rdata <= {1'b0, gate_r == AIW_BUF_FAULT, 4'h0,
                        mode_r};
        end
        `AIW_OFS_IRQ_SRC: reg_rdata <= src_flags;
        `AIW_OFS_WAKE_CFG: reg_rdata <= wake_select_and_pin_config_r;
        `AIW_OFS_IRQ_EN: reg_rdata <= interrupt_source_enable_r;
        `AIW_OFS_IRQ_ROUTE: reg_rdata <= interrupt_pin_routing_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // aiw_irq_wake_ctrl

// *** tb/aiw_host_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// host side of the two interrupt lines
// ----------------------------------------
module aiw_host_model (
  input wire logic o1,
  input wire logic oe1_n,
  input wire logic o2,
  input wire logic oe2_n,
  output logic w1,
  output logic w2
);
  // a released line is pulled up, so it never shows a stale level
  assign w1 = oe1_n ? 1'h1 : o1;
  assign w2 = oe2_n ? 1'h1 : o2;
endmodule // aiw_host_model

// *** tb/aiw_irq_wake_properties.sv ***
`timescale 1ns/10ps
`include "aiw_regs.svh"
module aiw_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire aiw_pkg::aiw_byte_t reg_addr,
  input wire aiw_pkg::aiw_byte_t reg_wdata,
  input wire aiw_pkg::aiw_byte_t reg_rdata,
  input wire aiw_pkg::aiw_byte_t event_flags,
  input wire logic buffer_empty,
  input wire logic buffer_flush,
  input wire logic buffer_input_block,
  input wire logic irq_pin_first_o,
  input wire logic irq_pin_first_oe_n,
  input wire logic irq_pin_second_o,
  input wire logic irq_pin_second_oe_n
);
  import aiw_pkg::*;
  aiw_byte_t cf_r, en_r, rt_r, sel;
  logic h1, h2, rw_a, map_a;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // shadow copies of the writable registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cf_r <= 8'h00;
      en_r <= 8'h00;
      rt_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `AIW_OFS_WAKE_CFG) cf_r <= reg_wdata;
      if (reg_addr == `AIW_OFS_IRQ_EN) en_r <= reg_wdata;
      if (reg_addr == `AIW_OFS_IRQ_ROUTE) rt_r <= reg_wdata;
    end
  end
  assign rw_a = reg_addr inside {8'h3A, 8'h3B, 8'h3C};
  assign map_a = rw_a || reg_addr inside {8'h14, 8'h15};
  assign sel = (reg_addr == 8'h3A) ? cf_r : (reg_addr == 8'h3B) ? en_r : rt_r;
  // bit 7 is the internal sleep/wake flag, not seen here
  assign h1 = |(event_flags[6:0] & en_r[6:0] & rt_r[6:0]);
  assign h2 = |(event_flags[6:0] & en_r[6:0] & ~rt_r[6:0]);
  chk_first_pin_level: assert property (!en_r[7] |=>
    irq_pin_first_o == ($past(h1) ~^ $past(cf_r[1])))
    else $error("first pin level wrong");
  chk_second_pin_level: assert property (!en_r[7] |=>
    irq_pin_second_o == ($past(h2) ~^ $past(cf_r[1])))
    else $error("second pin level wrong");
  chk_push_pull_drive: assert property (!cf_r[0] |=>
    !irq_pin_first_oe_n && !irq_pin_second_oe_n)
    else $error("push-pull pin released");
  chk_open_drain_release: assert property (cf_r[0] && !en_r[7] |=>
    irq_pin_first_oe_n != $past(h1) && irq_pin_second_oe_n != $past(h2))
    else $error("open-drain enable wrong");
  chk_reg_readback: assert property (reg_rd && !reg_wr && rw_a |=>
    reg_rdata == $past(sel))
    else $error("register readback wrong");
  chk_unmapped_zero: assert property (reg_rd && !map_a |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_block_holds: assert property (buffer_input_block
    && !buffer_empty |=> buffer_input_block)
    else $error("block dropped before empty");
  chk_flush_gate_off: assert property (buffer_flush |->
    !$past(cf_r[7]))
    else $error("flush with gate set");
  chk_error_clears: assert property (reg_rd && reg_addr == 8'h14 &&
    buffer_empty && $past(buffer_empty) |=> !reg_rdata[6])
    else $error("gate error after empty");
endmodule // aiw_checker
bind aiw_irq_wake_ctrl aiw_checker aiw_checker_inst (.mclk, .rst_n,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .event_flags,
  .buffer_empty, .buffer_flush, .buffer_input_block, .irq_pin_first_o,
  .irq_pin_first_oe_n, .irq_pin_second_o, .irq_pin_second_oe_n);

// *** tb/tb_aiw_irq_wake_ctrl.sv ***
`timescale 1ns/10ps
`include "aiw_regs.svh"
module tb_aiw_irq_wake_ctrl;
  import aiw_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd, sleep_wake_ack, auto_sleep_en;
  logic active_mode, sleep_request, sample_arrive, buffer_empty, w1, w2;
  logic buffer_flush, buffer_input_block, in_sleep;
  logic irq_pin_first_o, irq_pin_first_oe_n;
  logic irq_pin_second_o, irq_pin_second_oe_n;
  logic [2:0] s3;
  aiw_byte_t reg_addr, reg_wdata, reg_rdata, event_flags, f;
  int mismatches, compares, n, j, b;
  aiw_irq_wake_ctrl aiw_irq_wake_ctrl_inst (.mclk, .rst_n, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .event_flags,
    .sleep_wake_ack, .auto_sleep_en, .active_mode, .sleep_request,
    .sample_arrive, .buffer_empty, .buffer_flush, .buffer_input_block,
    .in_sleep, .irq_pin_first_o, .irq_pin_first_oe_n, .irq_pin_second_o,
    .irq_pin_second_oe_n);
  aiw_host_model aiw_host_model_inst (.o1(irq_pin_first_o),
    .oe1_n(irq_pin_first_oe_n), .o2(irq_pin_second_o),
    .oe2_n(irq_pin_second_oe_n), .w1, .w2);
  assign s3 = {buffer_flush, buffer_input_block, in_sleep};
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // access tasks and checks
  // ----------------------------------------
  task automatic complete_run;
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input aiw_byte_t got, input aiw_byte_t exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input aiw_byte_t a, input aiw_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input aiw_byte_t a, input aiw_byte_t e,
      input aiw_byte_t m);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    #1 chk(reg_rdata & m, e);
  endtask
  // k picks in_sleep, block or flush; returns on a clock edge
  task automatic waitv(input int k, input logic v);
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      #1;
      if (s3[k] === v) break;
    end
    if (n == 64) begin
      mismatches++;
      $display("[ERR] %0t wait timed out", $time);
      complete_run;
    end else begin
      @(posedge mclk);
    end
  endtask
  // pad level seen by the host; j[1] polarity, j[0] open drain
  function automatic logic lvl(input logic hit, input logic [1:0] j);
    return hit ? j[1] : (j[0] ? 1'h1 : !j[1]);
  endfunction
  initial begin
    {rst_n, reg_wr, reg_rd, sleep_wake_ack, sleep_request} = 5'h00;
    {sample_arrive, active_mode, auto_sleep_en, buffer_empty} = 4'h7;
    {reg_addr, reg_wdata, event_flags} = 24'h000000;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    for (j = 8'h3A; j < 8'h3D; j++) begin
      rd(8'(j), 8'h00, 8'hFF);
      wr(8'(j), 8'hA5 ^ 8'(j));
      rd(8'(j), 8'hA5 ^ 8'(j), 8'hFF);
    end
    wr(`AIW_OFS_IRQ_SRC, 8'hFF);
    rd(`AIW_OFS_IRQ_SRC, 8'h00, 8'hFF);
    rd(8'h40, 8'h00, 8'hFF);
    wr(`AIW_OFS_IRQ_EN, 8'h7F);
    wr(`AIW_OFS_IRQ_ROUTE, 8'h2A);
    for (j = 0; j < 4; j++) begin
      wr(`AIW_OFS_WAKE_CFG, 8'(j));
      for (b = 0; b < 8; b++) begin
        f = (b < 7) ? 8'h01 << b : 8'h7F;
        @(posedge mclk);
        event_flags <= f;
        repeat (2) @(posedge mclk);
        #1 chk({6'h00, w1, w2}, {6'h00, lvl(|(f & 8'h2A), 2'(j)),
          lvl(|(f & 8'h55), 2'(j))});
      end
    end
    wr(`AIW_OFS_WAKE_CFG, 8'h00);
    wr(`AIW_OFS_IRQ_EN, 8'h00);
    rd(`AIW_OFS_IRQ_SRC, 8'h7F, 8'h7F);
    chk({6'h00, w1, w2}, 8'h03);
    wr(`AIW_OFS_IRQ_EN, 8'hFF);
    for (j = 1; j < 6; j++) begin
      wr(`AIW_OFS_WAKE_CFG, 8'h00);
      event_flags <= 8'h00;
      sleep_request <= 1'h1;
      waitv(0, 1'h1);
      event_flags <= 8'h01 << j;
      repeat (10) @(posedge mclk);
      #1 chk({7'h00, in_sleep}, 8'h01);
      wr(`AIW_OFS_WAKE_CFG, 8'h02 << j);
      waitv(0, 1'h0);
    end
    event_flags <= 8'h41;
    waitv(0, 1'h1);
    wr(`AIW_OFS_WAKE_CFG, 8'h7C);
    repeat (10) @(posedge mclk);
    #1 chk({7'h00, in_sleep}, 8'h01);
    rd(`AIW_OFS_SYS_STATE, 8'h02, 8'h43);
    rd(`AIW_OFS_IRQ_SRC, 8'h80, 8'h80);
    @(posedge mclk);
    sleep_wake_ack <= 1'h1;
    @(posedge mclk);
    sleep_wake_ack <= 1'h0;
    rd(`AIW_OFS_IRQ_SRC, 8'h41, 8'hFF);
    wr(`AIW_OFS_WAKE_CFG, 8'hC0);
    buffer_empty <= 1'h0;
    event_flags <= 8'h20;
    sleep_request <= 1'h0;
    waitv(1, 1'h1);
    sample_arrive <= 1'h1;
    @(posedge mclk);
    sample_arrive <= 1'h0;
    rd(`AIW_OFS_SYS_STATE, 8'h40, 8'h40);
    chk({7'h00, buffer_input_block}, 8'h01);
    @(posedge mclk);
    buffer_empty <= 1'h1;
    waitv(1, 1'h0);
    rd(`AIW_OFS_SYS_STATE, 8'h00, 8'h40);
    wr(`AIW_OFS_WAKE_CFG, 8'h00);
    event_flags <= 8'h00;
    sleep_request <= 1'h1;
    waitv(2, 1'h1);
    complete_run;
  end
endmodule // tb_aiw_irq_wake_ctrl
